// *** logic/gated_pulse_and_period_measure.sv ***
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ns
`include "gpm_defs.svh"
module gated_pulse_and_period_measure
    import gpm_pkg::*;
#(
    parameter int NCH = 8,
    parameter int TW  = `TS_W,
    parameter int CW  = `CNT_W
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [NCH-1:0]     chan_in,
    input  wire logic               angle_window,
    input  wire logic               timeout_strobe,
    input  wire logic [`ADDR_W-1:0] addr,
    input  wire logic [31:0]        wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output logic      [31:0]        rdata,
    output logic                    width_valid,
    output logic                    period_valid
);
    import gpm_pkg::*;

    // ----------------------------------------
    // Inputs and timebase
    // ----------------------------------------
    logic [NCH-1:0] pin_s;
    logic           win_s;
    logic [TW-1:0]  now;

    // Window rides with the channels so both see the same latency
    input_sync #(.W(NCH + 1)) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({angle_window, chan_in}),
        .dout ({win_s, pin_s})
    );

    us_timebase #(.TW(TW)) u_tb (
        .clk (clk),
        .rst (rst),
        .ts  (now)
    );

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [7:0]        ctrl_q;
    logic [`CHAN_W-1:0] meas_ch_q;
    logic [`CHAN_W-1:0] ref_ch_q;
    logic [CW-1:0]     nth_q;
    logic [TW-1:0]     default_q;
    logic              cfg_wr;

    // A changed mode must not finish a half-seen pulse
    assign cfg_wr = wr && (addr == `REG_CTRL || addr == `REG_CHAN || addr == `REG_NTH);

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q    <= `CTRL_RST;
            meas_ch_q <= '0;
            ref_ch_q  <= `REF_CH_RST;
            nth_q     <= `ZERO_CNT;
            default_q <= `ZERO_TS;
        end else if (wr) begin
            unique case (addr)
                `REG_CTRL:    ctrl_q <= wdata[7:0];
                `REG_CHAN:    {ref_ch_q, meas_ch_q} <= wdata[5:0];
                `REG_NTH:     nth_q <= wdata[CW-1:0];
                `REG_DEFAULT: default_q <= wdata[TW-1:0];
                default:      ;
            endcase
        end
    end

    logic       async_m;
    logic       act_high;
    logic       qual_high;
    logic       period_rise;
    logic       freq_m;
    logic       preset_to;
    logic       init_req;
    qual_mode_e qmode;
    assign async_m     = ctrl_q[`C_ASYNC];
    assign act_high    = ctrl_q[`C_ACT_HIGH];
    assign qual_high   = ctrl_q[`C_QUAL_HIGH];
    assign qmode       = ctrl_q[`C_QUALIFY] ? QM_QUALIFY : QM_GATE;
    assign period_rise = ctrl_q[`C_PERIOD_RISE];
    assign freq_m      = ctrl_q[`C_FREQ];
    assign preset_to   = ctrl_q[`C_PRESET_TO];
    // Init bit and any write to the control, channel or n-th register restart the channel
    assign init_req    = ctrl_q[`C_INIT] || cfg_wr;

    // ----------------------------------------
    // Signal levels and edges
    // ----------------------------------------
    logic meas_raw;
    logic ref_raw;
    logic meas_q;
    logic ref_q;
    logic win_q;
    logic act;
    logic act_prev;
    logic qual;
    logic qual_prev;
    logic qual_rise;
    logic qual_fall;
    logic open_e;
    logic close_e;
    logic per_e;
    logic win_ok;

    // Level against its configured active polarity
    function automatic logic is_active(input logic lvl, input logic pol);
        is_active = (lvl == pol);
    endfunction : is_active

    assign meas_raw  = pin_s[meas_ch_q];
    assign ref_raw   = pin_s[ref_ch_q];
    assign act       = is_active(meas_raw, act_high);
    assign act_prev  = is_active(meas_q, act_high);
    assign qual      = is_active(ref_raw, qual_high);
    assign qual_prev = is_active(ref_q, qual_high);
    assign qual_rise = qual && !qual_prev;
    assign qual_fall = !qual && qual_prev;
    assign open_e    = act && !act_prev;
    assign close_e   = !act && act_prev;
    assign per_e    = period_rise ? (meas_raw && !meas_q) : (!meas_raw && meas_q);
    // Full-range window is a constant high window, so angle mode collapses to async
    assign win_ok   = async_m || win_s;

    always_ff @(posedge clk) begin
        if (rst) begin
            meas_q <= 1'b0;
            ref_q  <= 1'b0;
            win_q  <= 1'b0;
        end else begin
            meas_q <= meas_raw;
            ref_q  <= ref_raw;
            win_q  <= win_s;
        end
    end

    // ----------------------------------------
    // Pulse qualification
    // ----------------------------------------
    logic [TW-1:0] open_ts_q;
    logic          gate_ok_q;
    logic          seen_q;
    logic          encl_q;
    logic          inwin_q;
    logic          pulse_valid;
    logic          win_rise;

    assign win_rise = win_s && !win_q;

    always_ff @(posedge clk) begin
        if (rst || init_req) begin
            open_ts_q <= `ZERO_TS;
            gate_ok_q <= 1'b0;
            seen_q    <= 1'b0;
            encl_q    <= 1'b0;
            inwin_q   <= 1'b0;
        end else if (open_e) begin
            open_ts_q <= now;
            gate_ok_q <= qual;
            seen_q    <= 1'b0;
            encl_q    <= 1'b0;
            inwin_q   <= win_ok;
        end else if (act) begin
            if (!qual) begin
                gate_ok_q <= 1'b0;
            end
            if (qual_rise) begin
                seen_q <= 1'b1;
            end
            // Qualify pulse counts once it has also closed inside
            if (qual_fall && seen_q) begin
                encl_q <= 1'b1;
            end
            if (!win_ok || (!async_m && win_rise)) begin
                inwin_q <= 1'b0;
            end
        end
    end

    // Qualify mode: qualify pulse must open and close strictly inside the measured pulse; gate mode: it must stay active throughout
    always_comb begin
        pulse_valid = 1'b0;
        if (close_e && inwin_q && win_ok) begin
            unique case (qmode)
                QM_GATE:    pulse_valid = gate_ok_q && qual;
                QM_QUALIFY: pulse_valid = encl_q;
                default:    pulse_valid = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // Pulse selection
    // ----------------------------------------
    logic [CW-1:0] pcnt_q;
    logic          take;

    // Saturates so a long run cannot wrap back onto the n-th count

    always_ff @(posedge clk) begin
        if (rst || init_req) begin
            pcnt_q <= `ZERO_CNT;
        end else if (!async_m && win_rise) begin
            pcnt_q <= `ZERO_CNT;
        end else if (pulse_valid && pcnt_q != {CW{1'b1}}) begin
            pcnt_q <= pcnt_q + `ONE_CNT;
        end
    end

    // Zero selects every valid pulse; in async mode only the n-th after init
    assign take = pulse_valid && ((nth_q == `ZERO_CNT) || (pcnt_q + `ONE_CNT == nth_q));

    // ----------------------------------------
    // Period measurement
    // ----------------------------------------
    logic [TW-1:0] last_edge_q;
    logic          have_edge_q;
    logic          per_take;
    logic [TW-1:0] per_dt;
    logic [TW-1:0] edge_age;

    assign per_take = per_e && have_edge_q && win_ok;
    assign per_dt   = now - last_edge_q;
    assign edge_age = have_edge_q ? now - last_edge_q : `ZERO_TS;

    always_ff @(posedge clk) begin
        if (rst || init_req) begin
            last_edge_q <= `ZERO_TS;
            have_edge_q <= 1'b0;
        end else if (per_e) begin
            last_edge_q <= now;
            have_edge_q <= 1'b1;
        end
    end

    // Divider by repeated subtraction would stall; a simple scaled reciprocal suffices
    function automatic logic [TW-1:0] recip(input logic [TW-1:0] d);
        recip = (d == `ZERO_TS) ? {TW{1'b1}} : TW'(`FREQ_SCALE / d);
    endfunction : recip

    // ----------------------------------------
    // Results and timeout
    // ----------------------------------------
    logic [TW-1:0] width_q;
    logic [TW-1:0] period_q;
    logic          w_new_q;
    logic          p_new_q;
    logic          w_to_q;
    logic          p_to_q;
    logic          w_to, p_to;

    // A result landing on the strobe counts as produced, so no timeout
    assign w_to = timeout_strobe && !w_new_q && !take;
    assign p_to = timeout_strobe && !p_new_q && !per_take;

    always_ff @(posedge clk) begin
        if (rst || init_req) begin
            width_q     <= `ZERO_TS;
            w_new_q     <= 1'b0;
            w_to_q      <= 1'b0;
            width_valid <= 1'b0;
        end else begin
            width_valid <= take || w_to;
            if (take) begin
                width_q <= now - open_ts_q;
                w_new_q <= !timeout_strobe;
                w_to_q  <= 1'b0;
            end else if (w_to) begin
                w_to_q <= 1'b1;
                if (preset_to) begin
                    width_q <= default_q;
                end else begin
                    width_q <= act ? now - open_ts_q : `ZERO_TS;
                end
            end else if (timeout_strobe) begin
                w_new_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || init_req) begin
            period_q     <= `ZERO_TS;
            p_new_q      <= 1'b0;
            p_to_q       <= 1'b0;
            period_valid <= 1'b0;
        end else begin
            period_valid <= per_take || p_to;
            if (per_take) begin
                period_q <= freq_m ? recip(per_dt) : per_dt;
                p_new_q  <= !timeout_strobe;
                p_to_q   <= 1'b0;
            end else if (p_to) begin
                p_to_q <= 1'b1;
                if (preset_to) begin
                    period_q <= default_q;
                end else begin
                    period_q <= freq_m ? recip(edge_age) : edge_age;
                end
            end else if (timeout_strobe) begin
                p_new_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Read data stands one cycle only; zero outside reads
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            unique case (addr)
                `REG_CTRL:    rdata <= {24'h00_0000, ctrl_q};
                `REG_CHAN:    rdata <= {26'h000_0000, ref_ch_q, meas_ch_q};
                `REG_NTH:     rdata <= {24'h00_0000, nth_q};
                `REG_DEFAULT: rdata <= default_q;
                `REG_WIDTH:   rdata <= width_q;
                `REG_PERIOD:  rdata <= period_q;
                `REG_STATUS:  rdata <= {28'h000_0000, p_to_q, w_to_q, act, have_edge_q};
                default:      rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule : gated_pulse_and_period_measure

// *** logic/gpm_defs.svh ***
`ifndef GPM_DEFS_SVH
`define GPM_DEFS_SVH
`define TS_W          32
`define CNT_W         8
`define CHAN_W        3
`define ADDR_W        4
`define US_NS         1000
`define CLK_NS        10
`define ZERO_TS       32'h0000_0000
`define ZERO_CNT      8'h00
`define ONE_CNT       8'h01
`define ONE_TS        32'h0000_0001
`define FREQ_SCALE    32'h000f_4240
`define CTRL_RST      8'h03
`define REF_CH_RST    3'h1
// Register offsets
`define REG_CTRL      4'h0
`define REG_CHAN      4'h1
`define REG_NTH       4'h2
`define REG_DEFAULT   4'h3
`define REG_WIDTH     4'h4
`define REG_PERIOD    4'h5
`define REG_STATUS    4'h6
// Control field positions
`define C_ASYNC       0
`define C_ACT_HIGH    1
`define C_QUAL_HIGH   2
`define C_QUALIFY     3
`define C_PERIOD_RISE 4
`define C_FREQ        5
`define C_PRESET_TO   6
`define C_INIT        7
`endif

// *** logic/gpm_pkg.sv ***
package gpm_pkg;
    typedef enum logic [1:0] {QM_GATE, QM_QUALIFY} qual_mode_e;
    typedef logic [31:0] ts_t;
endpackage : gpm_pkg

// *** logic/input_sync.sv ***
`timescale 1ns/1ns
`include "gpm_defs.svh"
module input_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    // Change accepted only once stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            dout <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : input_sync

// *** logic/us_timebase.sv ***
`timescale 1ns/1ns
`include "gpm_defs.svh"
module us_timebase #(
    parameter int TW = `TS_W
) (
    input  wire logic          clk,
    input  wire logic          rst,
    output logic      [TW-1:0] ts
);
    localparam int DIV = `US_NS / `CLK_NS;
    logic [6:0] div_q;
    // Free-running microsecond stamp
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 7'h00;
            ts    <= '0;
        end else if (div_q == 7'(DIV - 1)) begin
            div_q <= 7'h00;
            ts    <= ts + TW'(1);
        end else begin
            div_q <= div_q + 7'h01;
        end
    end
endmodule : us_timebase

// *** sim/gated_pulse_and_period_measure_tb.sv ***
`timescale 1ns/1ns
`include "gpm_defs.svh"
module gated_pulse_and_period_measure_tb;
    logic        clk;
    logic        rst;
    logic [7:0]  chan_in;
    logic        angle_window;
    logic        timeout_strobe;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [31:0] got;
    logic        width_valid;
    logic        period_valid;
    int          fails;
    int          n_tests;
    int          w;
    int          cfg_q[$] = '{32'h11, 32'h01, 32'h31, 32'h10};
    int          exp_q[$] = '{4, 4, 250000, 4};
    gated_pulse_and_period_measure u_gated_pulse_and_period_measure (.clk(clk), .rst(rst),
        .chan_in(chan_in), .angle_window(angle_window), .timeout_strobe(timeout_strobe),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .width_valid(width_valid), .period_valid(period_valid));
    sig_source u_sig_source (.clk(clk), .chan(chan_in));
    // ----------
    // Bus and check helpers
    // ----------
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task miss(input string s);
        fails++;
        $display("mismatch at %0t: %s", $time, s);
    endtask : miss
    task wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task rreg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : rreg
    task check(input int e, input int tol);
        n_tests++;
        if (^got === 1'bx || int'(got) < e - tol || int'(got) > e + tol) begin
            miss($sformatf("got %0d expected %0d", got, e));
        end
    endtask : check
    task strobe(input int settle);
        @(posedge clk);
        timeout_strobe <= 1'b1;
        @(posedge clk);
        timeout_strobe <= 1'b0;
        repeat (settle) @(posedge clk);
    endtask : strobe
    // Negative expectation: no result may appear; otherwise the result is read back and checked
    task expect_res(input bit per, input int e, input int tol);
        bit seen;
        seen = 0;
        for (int i = 0; i < 1000 && !seen; i++) begin
            @(posedge clk);
            seen = per ? period_valid === 1'b1 : width_valid === 1'b1;
        end
        if (e < 0) begin
            n_tests++;
            if (seen) begin
                miss("unexpected result");
            end
        end else if (!seen) begin
            miss("result wait ran out");
            report_and_stop;
        end else begin
            rreg(per ? `REG_PERIOD : `REG_WIDTH);
            check(e, tol);
        end
    endtask : expect_res
    // ----------
    // Scenarios
    // ----------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst, angle_window} = 2'b11;
        {timeout_strobe, wr, rd, addr, wdata} = '0;
        fails = 0;
        n_tests = 0;
        void'($urandom(66470));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wreg(`REG_CHAN, 32'h08);
        wreg(`REG_CTRL, 32'h07);
        u_sig_source.set(1, 1, 10);
        for (int k = 0; k < 3; k++) begin
            w = 2 + $urandom_range(6);
            u_sig_source.pulse(0, 1, w);
            expect_res(0, w, 1);
        end
        u_sig_source.set(1, 0, 10);
        u_sig_source.set(0, 1, 10);
        u_sig_source.set(1, 1, 10);
        u_sig_source.set(0, 0, 0);
        expect_res(0, -1, 0);
        wreg(`REG_CHAN, 32'h10);
        u_sig_source.pulse(0, 1, 3);
        expect_res(0, -1, 0);
        u_sig_source.set(2, 1, 10);
        u_sig_source.pulse(0, 1, 3);
        expect_res(0, 3, 1);
        wreg(`REG_CTRL, 32'h0f);
        u_sig_source.set(2, 0, 10);
        u_sig_source.set(0, 1, 99);
        u_sig_source.set(2, 1, 99);
        u_sig_source.set(2, 0, 99);
        u_sig_source.set(0, 0, 0);
        expect_res(0, 3, 1);
        u_sig_source.pulse(0, 1, 2);
        expect_res(0, -1, 0);
        wreg(`REG_CTRL, 32'h01);
        u_sig_source.set(0, 1, 10);
        u_sig_source.pulse(0, 0, 4);
        expect_res(0, 4, 1);
        u_sig_source.set(2, 1, 10);
        u_sig_source.pulse(0, 0, 2);
        expect_res(0, -1, 0);
        u_sig_source.set(0, 0, 10);
        wreg(`REG_NTH, 32'h02);
        rreg(`REG_NTH);
        wreg(`REG_CTRL, 32'h07);
        for (int k = 1; k <= 3; k++) begin
            u_sig_source.pulse(0, 1, k + 1);
            expect_res(0, k == 2 ? 3 : -1, 1);
        end
        wreg(`REG_NTH, 32'h00);
        u_sig_source.pulse(0, 1, 2);
        expect_res(0, 2, 1);
        wreg(`REG_CTRL, 32'h87);
        u_sig_source.pulse(0, 1, 2);
        expect_res(0, -1, 0);
        wreg(`REG_CTRL, 32'h06);
        u_sig_source.pulse(0, 1, 2);
        expect_res(0, 2, 1);
        u_sig_source.set(0, 1, 50);
        angle_window <= 1'b0;
        u_sig_source.set(0, 0, 0);
        expect_res(0, -1, 0);
        wreg(`REG_NTH, 32'h02);
        for (int k = 0; k < 2; k++) begin
            u_sig_source.set(0, 0, 10);
            angle_window <= 1'b1;
            u_sig_source.pulse(0, 1, 2);
            expect_res(0, -1, 0);
            u_sig_source.pulse(0, 1, 3);
            expect_res(0, 3, 1);
            angle_window <= 1'b0;
        end
        angle_window <= 1'b1;
        wreg(`REG_NTH, 32'h00);
        foreach (cfg_q[i]) begin
            wreg(`REG_CTRL, cfg_q[i]);
            fork
                u_sig_source.toggle(0, 200, 6);
            join_none
            expect_res(1, exp_q[i], i == 2 ? 83334 : 1);
            wait fork;
        end
        angle_window <= 1'b0;
        fork
            u_sig_source.toggle(0, 200, 6);
        join_none
        expect_res(1, -1, 0);
        wait fork;
        angle_window <= 1'b1;
        wreg(`REG_DEFAULT, 32'h4d2);
        rreg(`REG_DEFAULT);
        check(1234, 0);
        rreg(4'hf);
        check(0, 0);
        wreg(`REG_CTRL, 32'h47);
        strobe(8);
        strobe(0);
        expect_res(0, 1234, 0);
        wreg(`REG_CTRL, 32'h07);
        strobe(8);
        u_sig_source.set(0, 1, 300);
        strobe(0);
        expect_res(0, 3, 1);
        u_sig_source.set(0, 0, 10);
        strobe(0);
        expect_res(0, -1, 0);
        strobe(0);
        expect_res(0, 0, 0);
        rreg(`REG_STATUS);
        check(32'hd, 0);
        for (int k = 0; k < 2; k++) begin
            wreg(`REG_CTRL, k ? 32'h31 : 32'h11);
            u_sig_source.toggle(0, 200, 4);
            strobe(8);
            repeat (490) @(posedge clk);
            strobe(0);
            expect_res(1, k ? 111111 : 9, k ? 13889 : 1);
        end
        report_and_stop;
    end
endmodule : gated_pulse_and_period_measure_tb

// *** sim/gpm_checker.sv ***
`timescale 1ns/1ns
`include "gpm_defs.svh"
module gpm_checker #(
    parameter int NCH = 8
) (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic [NCH-1:0]     chan_in,
    input wire logic               timeout_strobe,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [31:0]        wdata,
    input wire logic               wr,
    input wire logic               rd,
    input wire logic [31:0]        rdata,
    input wire logic               width_valid,
    input wire logic               period_valid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside a read");
    chk_unmapped_read: assert property (rd && addr > `REG_STATUS |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_default_back: assert property (wr && addr == `REG_DEFAULT ##2 rd && addr == `REG_DEFAULT
        |=> rdata == $past(wdata, 3))
        else $error("default value readback wrong");
    chk_nth_back: assert property (wr && addr == `REG_NTH ##2 rd && addr == `REG_NTH
        |=> rdata[7:0] == $past(wdata[7:0], 3))
        else $error("pulse number readback wrong");
    chk_width_single: assert property (width_valid |=> !width_valid)
        else $error("width flag longer than one cycle");
    chk_period_single: assert property (period_valid |=> !period_valid)
        else $error("period flag longer than one cycle");
    // No edge and no check: nothing may be written
    chk_quiet_width: assert property ((!timeout_strobe && $stable(chan_in))[*6] |=> !width_valid)
        else $error("width result without cause");
    chk_quiet_period: assert property ((!timeout_strobe && $stable(chan_in))[*6] |=> !period_valid)
        else $error("period result without cause");
    chk_reset_clean: assert property ($fell(rst) |-> !width_valid && !period_valid && rdata == 32'h0)
        else $error("outputs not clear after reset");
endmodule : gpm_checker

bind gated_pulse_and_period_measure gpm_checker #(.NCH(NCH)) u_gpm_checker (
    .clk(clk), .rst(rst), .chan_in(chan_in), .timeout_strobe(timeout_strobe), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .width_valid(width_valid),
    .period_valid(period_valid));

// *** sim/sig_source.sv ***
`timescale 1ns/1ns
module sig_source #(
    parameter int NCH = 8
) (
    input  wire logic           clk,
    output logic      [NCH-1:0] chan
);
    initial chan = '0;
    // Levels move just after an edge, as a clocked source would
    task set(input int ch, input logic v, input int cyc);
        @(posedge clk);
        chan[ch] <= v;
        repeat (cyc) @(posedge clk);
    endtask : set
    task pulse(input int ch, input logic lvl, input int us);
        set(ch, lvl, us * 100 - 1);
        // Return at the closing edge so the caller sees the one-cycle result
        set(ch, ~lvl, 0);
    endtask : pulse
    task toggle(input int ch, input int half, input int n);
        repeat (n) set(ch, ~chan[ch], half - 1);
    endtask : toggle
endmodule : sig_source
